// File: pcdaf_pkg.sv
// package for the port c / port d alternate function override block
// assumes a 10 MHz system clock and a 32-bit avalon-mm register slave

package pcdaf_pkg;

  // ***************************************************
  // register map, byte addresses on the avalon slave
  // ***************************************************
  localparam logic [4:0] PORTC_DATA_OFS = 5'h00;
  localparam logic [4:0] PORTC_DIR_OFS = 5'h04;
  localparam logic [4:0] PORTC_PIN_OFS = 5'h08;
  localparam logic [4:0] PORTD_DATA_OFS = 5'h0c;
  localparam logic [4:0] PORTD_DIR_OFS = 5'h10;
  localparam logic [4:0] PORTD_PIN_OFS = 5'h14;
  localparam logic [4:0] CTRL_OFS = 5'h18;

  // ***************************************************
  // field positions and reset values
  // ***************************************************
  localparam int CTRL_PUD_BIT = 0;
  localparam int PORTC_GAP_BIT = 3;
  localparam logic [7:0] PORTC_IMPL_MASK = 8'hf7;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic CTRL_PUD_RESET = 1'b0;

  // port d bit roles
  localparam int PD_CTS = 7;
  localparam int PD_RTS = 6;
  localparam int PD_XCK = 5;
  localparam int PD_TXD = 3;
  localparam int PD_RXD = 2;
  localparam int PD_AIP = 1;
  localparam int PD_OCB = 0;

endpackage

// File: pcdaf_top.sv
// port c / port d pin override logic with its port registers
// assumes peripheral controls arrive on sys_clk_i; pad inputs are asynchronous
// Notes on behaviour
// - upper port c: no pull or direction override; bits 6,5 from timer1 compares
// - pc2 input kept on while pin-change 11 enabled; pc1, pc0 never overridden
// - cts forces pd7 input with gated pull-up; rts forces pd6 output
// - transmitter enable makes pd3 an output, pull-up off, driving tx data
// - tx pin is output when transmitter enabled, whatever its direction bit
// - rx pin is input when receiver enabled, whatever its direction bit
// - forced rx input keeps pull-up from port bit 2, gated by pull-up disable
// - sync clock pin direction follows pd5 direction bit
// - sync clock function only in synchronous mode, else plain port i/o
// - timer0 compare b output drives pd0 value when enabled
// - sampled cts level gates the serial transmitter
// - receiver drives rts output from its own receive state
// - pd5 feeds pin-change source 12, input kept on while enabled
// - pd3..0 feed irq 3..0, pd4 irq 5, pd7,6 irq 7,6
// - pd7 input also drives timer0 count source
// - pd2 goes to comparator negative input; enabling it overrides digital input
// - pd1 goes to comparator positive input; enabling it overrides digital input

`timescale 1ns/100ps
`default_nettype none

module pcdaf_top (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // port c pads
  input wire logic [7:0] portc_pad_i,
  output logic [7:0] portc_pad_o,
  output logic [7:0] portc_pad_oe_o,
  output logic [7:0] portc_pullup_o,
  output logic [7:0] portc_input_en_o,
  // port d pads
  input wire logic [7:0] portd_pad_i,
  output logic [7:0] portd_pad_o,
  output logic [7:0] portd_pad_oe_o,
  output logic [7:0] portd_pullup_o,
  output logic [7:0] portd_input_en_o,
  // timers
  input wire logic timer1_compare_a_en_i,
  input wire logic timer1_compare_a_out_i,
  input wire logic timer1_compare_b_en_i,
  input wire logic timer1_compare_b_out_i,
  input wire logic timer0_compare_b_en_i,
  input wire logic timer0_compare_b_out_i,
  output logic timer0_count_input_o,
  // serial unit
  input wire logic serial_tx_enable_i,
  input wire logic serial_tx_data_i,
  input wire logic serial_rx_enable_i,
  input wire logic serial_rx_ready_i,
  input wire logic serial_cts_en_i,
  input wire logic serial_rts_en_i,
  input wire logic serial_sync_mode_i,
  input wire logic serial_sync_clock_out_i,
  output logic serial_rx_data_o,
  output logic serial_tx_allow_o,
  output logic serial_sync_clock_o,
  // interrupt and comparator inputs
  input wire logic [7:0] ext_irq_en_i,
  input wire logic [12:8] pin_change_en_i,
  input wire logic comparator_pos_en_i,
  input wire logic comparator_neg_en_i,
  input wire logic sleep_i,
  output logic [7:0] ext_irq_o,
  output logic [12:8] pin_change_o,
  output logic comparator_pos_in_o,
  output logic comparator_neg_in_o
);

  // ***************************************************
  // registers written by software
  // ***************************************************
  logic [7:0] portc_data, portc_dir, portd_data, portd_dir;
  logic global_pullup_disable;
  logic [7:0] next_portc_data, next_portc_dir, next_portd_data, next_portd_dir;
  logic next_global_pullup_disable;
  logic bus_ack, next_bus_ack;
  logic [31:0] next_readdata;
  logic bus_req, wr_take, lane0;
  logic [7:0] wbyte;
  logic [7:0] portc_pin, portd_pin;

  assign bus_req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~(bus_ack & ce_i);
  assign wr_take = avs_write_i & bus_ack;
  assign lane0 = avs_byteenable_i[0];
  assign wbyte = avs_writedata_i[7:0];

  always_comb begin
    next_portc_data = portc_data;
    next_portc_dir = portc_dir;
    next_portd_data = portd_data;
    next_portd_dir = portd_dir;
    next_global_pullup_disable = global_pullup_disable;
    next_bus_ack = bus_req & ~bus_ack;
    next_readdata = avs_readdata_o;
    if (wr_take && lane0) begin
      case (avs_address_i)
        pcdaf_pkg::PORTC_DATA_OFS: next_portc_data = wbyte & pcdaf_pkg::PORTC_IMPL_MASK;
        pcdaf_pkg::PORTC_DIR_OFS: next_portc_dir = wbyte & pcdaf_pkg::PORTC_IMPL_MASK;
        pcdaf_pkg::PORTD_DATA_OFS: next_portd_data = wbyte;
        pcdaf_pkg::PORTD_DIR_OFS: next_portd_dir = wbyte;
        pcdaf_pkg::CTRL_OFS: next_global_pullup_disable = wbyte[pcdaf_pkg::CTRL_PUD_BIT];
        default: next_global_pullup_disable = global_pullup_disable;
      endcase
    end
    if (avs_read_i && !bus_ack) begin
      case (avs_address_i)
        pcdaf_pkg::PORTC_DATA_OFS: next_readdata = {24'h000000, portc_data};
        pcdaf_pkg::PORTC_DIR_OFS: next_readdata = {24'h000000, portc_dir};
        pcdaf_pkg::PORTC_PIN_OFS: next_readdata = {24'h000000, portc_pin};
        pcdaf_pkg::PORTD_DATA_OFS: next_readdata = {24'h000000, portd_data};
        pcdaf_pkg::PORTD_DIR_OFS: next_readdata = {24'h000000, portd_dir};
        pcdaf_pkg::PORTD_PIN_OFS: next_readdata = {24'h000000, portd_pin};
        pcdaf_pkg::CTRL_OFS: next_readdata = {31'h00000000, global_pullup_disable};
        default: next_readdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      portc_data <= pcdaf_pkg::PORT_RESET;
      portc_dir <= pcdaf_pkg::DIR_RESET;
      portd_data <= pcdaf_pkg::PORT_RESET;
      portd_dir <= pcdaf_pkg::DIR_RESET;
      global_pullup_disable <= pcdaf_pkg::CTRL_PUD_RESET;
      bus_ack <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end else if (ce_i) begin
      portc_data <= next_portc_data;
      portc_dir <= next_portc_dir;
      portd_data <= next_portd_data;
      portd_dir <= next_portd_dir;
      global_pullup_disable <= next_global_pullup_disable;
      bus_ack <= next_bus_ack;
      avs_readdata_o <= next_readdata;
    end
  end

  // ***************************************************
  // pad input synchronisers, three stages with agreement
  // ***************************************************
  logic [15:0] pad_s1, pad_s2, pad_s3, pad_filt, next_pad_filt;
  logic [15:0] die_all;

  always_comb begin
    // filtered level moves only once stages two and three agree
    next_pad_filt = (pad_s2 & pad_s3) | (pad_filt & (pad_s2 | pad_s3));
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pad_s1 <= 16'h0000;
      pad_s2 <= 16'h0000;
      pad_s3 <= 16'h0000;
      pad_filt <= 16'h0000;
    end else if (ce_i) begin
      pad_s1 <= {portd_pad_i, portc_pad_i};
      pad_s2 <= pad_s1;
      pad_s3 <= pad_s2;
      pad_filt <= next_pad_filt;
    end
  end

  // a disabled digital input reads as zero
  assign die_all = {portd_input_en_o, portc_input_en_o};
  assign portc_pin = pad_filt[7:0] & die_all[7:0] & pcdaf_pkg::PORTC_IMPL_MASK;
  assign portd_pin = pad_filt[15:8] & die_all[15:8];

  // ***************************************************
  // override signal sets per pin
  // ***************************************************
  logic [15:0] pullup_override_enable, pullup_override_value, direction_override_enable, direction_override_value, port_value_override_enable, port_value_override_value, input_enable_override_enable, input_enable_override_value;
  logic [15:0] port_all, dir_all;
  logic xck_drive;

  assign port_all = {portd_data, portc_data};
  assign dir_all = {portd_dir, portc_dir};
  assign xck_drive = serial_sync_mode_i & portd_dir[pcdaf_pkg::PD_XCK];

  always_comb begin
    pullup_override_enable = 16'h0000;
    pullup_override_value = 16'h0000;
    direction_override_enable = 16'h0000;
    direction_override_value = 16'h0000;
    port_value_override_enable = 16'h0000;
    port_value_override_value = 16'h0000;
    input_enable_override_enable = 16'h0000;
    input_enable_override_value = 16'h0000;
    // port c: only value overrides on 6,5 and input-enable keeps, none on 1,0
    port_value_override_enable[6] = timer1_compare_a_en_i;
    port_value_override_value[6] = timer1_compare_a_out_i;
    port_value_override_enable[5] = timer1_compare_b_en_i;
    port_value_override_value[5] = timer1_compare_b_out_i;
    input_enable_override_enable[7] = ext_irq_en_i[4];
    input_enable_override_enable[6] = pin_change_en_i[8];
    input_enable_override_enable[5] = pin_change_en_i[9];
    input_enable_override_enable[4] = pin_change_en_i[10];
    input_enable_override_enable[2] = pin_change_en_i[11];
    input_enable_override_value[7:4] = 4'hf;
    input_enable_override_value[2] = 1'b1;
    // port d
    pullup_override_enable[8 + pcdaf_pkg::PD_CTS] = serial_cts_en_i;
    pullup_override_value[8 + pcdaf_pkg::PD_CTS] = portd_data[pcdaf_pkg::PD_CTS] & ~global_pullup_disable;
    direction_override_enable[8 + pcdaf_pkg::PD_CTS] = serial_cts_en_i;
    pullup_override_enable[8 + pcdaf_pkg::PD_RTS] = serial_rts_en_i;
    direction_override_enable[8 + pcdaf_pkg::PD_RTS] = serial_rts_en_i;
    direction_override_value[8 + pcdaf_pkg::PD_RTS] = 1'b1;
    port_value_override_enable[8 + pcdaf_pkg::PD_RTS] = serial_rts_en_i;
    port_value_override_value[8 + pcdaf_pkg::PD_RTS] = ~serial_rx_ready_i;
    port_value_override_enable[8 + pcdaf_pkg::PD_XCK] = xck_drive;
    port_value_override_value[8 + pcdaf_pkg::PD_XCK] = serial_sync_clock_out_i;
    pullup_override_enable[8 + pcdaf_pkg::PD_TXD] = serial_tx_enable_i;
    direction_override_enable[8 + pcdaf_pkg::PD_TXD] = serial_tx_enable_i;
    direction_override_value[8 + pcdaf_pkg::PD_TXD] = 1'b1;
    port_value_override_enable[8 + pcdaf_pkg::PD_TXD] = serial_tx_enable_i;
    port_value_override_value[8 + pcdaf_pkg::PD_TXD] = serial_tx_data_i;
    pullup_override_enable[8 + pcdaf_pkg::PD_RXD] = serial_rx_enable_i;
    pullup_override_value[8 + pcdaf_pkg::PD_RXD] = portd_data[pcdaf_pkg::PD_RXD] & ~global_pullup_disable;
    direction_override_enable[8 + pcdaf_pkg::PD_RXD] = serial_rx_enable_i;
    port_value_override_enable[8 + pcdaf_pkg::PD_OCB] = timer0_compare_b_en_i;
    port_value_override_value[8 + pcdaf_pkg::PD_OCB] = timer0_compare_b_out_i;
    // digital input keeps for irqs, pin change 12 and cts; comparator turns it off
    input_enable_override_enable[15] = ext_irq_en_i[7] | serial_cts_en_i;
    input_enable_override_enable[14] = ext_irq_en_i[6];
    input_enable_override_enable[13] = pin_change_en_i[12];
    input_enable_override_enable[12] = ext_irq_en_i[5];
    input_enable_override_enable[11] = ext_irq_en_i[3];
    input_enable_override_enable[10] = ext_irq_en_i[2] | comparator_neg_en_i;
    input_enable_override_enable[9] = ext_irq_en_i[1] | comparator_pos_en_i;
    input_enable_override_enable[8] = ext_irq_en_i[0];
    input_enable_override_value[15:11] = 5'h1f;
    input_enable_override_value[10] = ~comparator_neg_en_i;
    input_enable_override_value[9] = ~comparator_pos_en_i;
    input_enable_override_value[8] = 1'b1;
  end

  // ***************************************************
  // per-pin resolution of overrides against port settings
  // ***************************************************
  logic [15:0] res_pull, res_dir, res_val, res_die;

  for (genvar i = 0; i < 16; i++) begin : g_pin
    logic base_pull;
    assign base_pull = port_all[i] & ~dir_all[i] & ~global_pullup_disable;
    assign res_pull[i] = pullup_override_enable[i] ? pullup_override_value[i] : base_pull;
    assign res_dir[i] = direction_override_enable[i] ? direction_override_value[i] : dir_all[i];
    assign res_val[i] = port_value_override_enable[i] ? port_value_override_value[i] : port_all[i];
    assign res_die[i] = input_enable_override_enable[i] ? input_enable_override_value[i] : ~sleep_i;
  end

  // ***************************************************
  // registered pad controls and peripheral inputs
  // ***************************************************
  logic [15:0] next_pad_out, next_pad_oe, next_pull, next_die;
  logic [7:0] next_ext_irq;
  logic [12:8] next_pin_change;
  logic next_t0, next_rxd, next_tx_allow, next_xck, next_cmp_pos, next_cmp_neg;
  logic [15:0] din;
  assign din = pad_filt & die_all;
  always_comb begin
    next_pad_out = res_val;
    next_pad_oe = res_dir;
    // a pin that drives out has no pull-up
    next_pull = res_pull & ~res_dir;
    next_die = res_die;
    next_ext_irq = {din[15], din[14], din[12], din[7], din[11:8]};
    next_pin_change = {din[13], din[2], din[4], din[5], din[6]};
    next_t0 = din[8 + pcdaf_pkg::PD_CTS];
    next_rxd = din[8 + pcdaf_pkg::PD_RXD];
    // cts low lets the transmitter run
    next_tx_allow = ~serial_cts_en_i | ~din[8 + pcdaf_pkg::PD_CTS];
    next_xck = serial_sync_mode_i & ~portd_dir[pcdaf_pkg::PD_XCK] & din[13];
    next_cmp_pos = pad_filt[8 + pcdaf_pkg::PD_AIP];
    next_cmp_neg = pad_filt[8 + pcdaf_pkg::PD_RXD];
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      {portd_pad_o, portc_pad_o} <= 16'h0000;
      {portd_pad_oe_o, portc_pad_oe_o} <= 16'h0000;
      {portd_pullup_o, portc_pullup_o} <= 16'h0000;
      {portd_input_en_o, portc_input_en_o} <= 16'hffff;
      ext_irq_o <= 8'h00;
      pin_change_o <= 5'h00;
      timer0_count_input_o <= 1'b0;
      serial_rx_data_o <= 1'b0;
      serial_tx_allow_o <= 1'b1;
      serial_sync_clock_o <= 1'b0;
      comparator_pos_in_o <= 1'b0;
      comparator_neg_in_o <= 1'b0;
    end else if (ce_i) begin
      {portd_pad_o, portc_pad_o} <= next_pad_out;
      {portd_pad_oe_o, portc_pad_oe_o} <= next_pad_oe;
      {portd_pullup_o, portc_pullup_o} <= next_pull;
      {portd_input_en_o, portc_input_en_o} <= next_die;
      ext_irq_o <= next_ext_irq;
      pin_change_o <= next_pin_change;
      timer0_count_input_o <= next_t0;
      serial_rx_data_o <= next_rxd;
      serial_tx_allow_o <= next_tx_allow;
      serial_sync_clock_o <= next_xck;
      comparator_pos_in_o <= next_cmp_pos;
      comparator_neg_in_o <= next_cmp_neg;
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  tx_pin_drive_a: assert property (
    ce_i && serial_tx_enable_i |=> portd_pad_oe_o[3] && !portd_pullup_o[3]
      && portd_pad_o[3] == $past(serial_tx_data_i))
    else $error("tx pin not driven with tx data");
  rx_pin_input_a: assert property (
    ce_i && serial_rx_enable_i |=> !portd_pad_oe_o[2]
      && portd_pullup_o[2] == $past(portd_data[2] & ~global_pullup_disable))
    else $error("rx pin not forced to input with its pull-up");
  cts_rts_dir_a: assert property (
    ce_i && serial_cts_en_i && serial_rts_en_i |=> !portd_pad_oe_o[7] && portd_pad_oe_o[6])
    else $error("flow control pins in wrong direction");
  rts_value_a: assert property (
    ce_i && serial_rts_en_i |=> portd_pad_o[6] == !$past(serial_rx_ready_i))
    else $error("rts does not follow receive state");
  timer1_value_a: assert property (
    ce_i && timer1_compare_a_en_i |=> portc_pad_o[6] == $past(timer1_compare_a_out_i)
      && portc_pad_oe_o[6] == $past(portc_dir[6]))
    else $error("timer1 compare a not on pc6");
  timer0_value_a: assert property (
    ce_i && timer0_compare_b_en_i |=> portd_pad_o[0] == $past(timer0_compare_b_out_i)
      && portd_pad_oe_o[0] == $past(portd_dir[0]))
    else $error("timer0 compare b not on pd0");
  xck_plain_a: assert property (
    ce_i && !serial_sync_mode_i |=> portd_pad_o[5] == $past(portd_data[5])
      && portd_pad_oe_o[5] == $past(portd_dir[5]))
    else $error("pd5 not plain port outside sync mode");
  pc_low_plain_a: assert property (
    ce_i |=> portc_pad_o[1:0] == $past(portc_data[1:0])
      && portc_pad_oe_o[1:0] == $past(portc_dir[1:0]))
    else $error("pc1 or pc0 overridden");
  comp_input_off_a: assert property (
    ce_i && comparator_neg_en_i && comparator_pos_en_i |=> !portd_input_en_o[2]
      && !portd_input_en_o[1])
    else $error("digital input left on under comparator");
  bus_answer_a: assert property (
    ce_i && bus_req && avs_waitrequest_o ##1 ce_i && bus_req |-> !avs_waitrequest_o)
    else $error("bus request not answered after one wait cycle");

endmodule

`default_nettype wire

// File: pcdaf_board.sv
// board circuitry model for one 8-bit port: resolves each pad wire
// assumes a free-running sys_clk_i; board drivers yield to the chip
`timescale 1ns/100ps
`default_nettype none

module pcdaf_board (
  // clock
  input wire logic sys_clk_i,
  // chip side of the pads
  input wire logic [7:0] pad_o_i,
  input wire logic [7:0] pad_oe_i,
  input wire logic [7:0] pullup_i,
  // board drivers
  input wire logic [7:0] drv_en_i,
  input wire logic [7:0] drv_val_i,
  // resolved wire level
  output logic [7:0] level_o
);
  logic [7:0] last = 8'h00;

  // a floating pin shows the inverse of its last level, so it never settles
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe_i[i]) begin
        level_o[i] = pad_o_i[i];
      end else if (drv_en_i[i]) begin
        level_o[i] = drv_val_i[i];
      end else if (pullup_i[i]) begin
        level_o[i] = 1'b1;
      end else begin
        level_o[i] = ~last[i];
      end
    end
  end

  always @(posedge sys_clk_i) begin
    last <= level_o;
  end
endmodule

`default_nettype wire

// File: pcdaf_top_tb.sv
// self-checking bench for the port c / port d override block
// assumes one avalon wait cycle and a 3-flop pad synchroniser
`timescale 1ns/100ps
`default_nettype none

module pcdaf_top_tb;
  // ***************************************************
  // stimulus and observed signals
  // ***************************************************
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic rd = 1'b0, wr = 1'b0, wreq;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [3:0] be = 4'hf;
  logic [7:0] c_o, c_oe, c_pu, c_ie, d_o, d_oe, d_pu, d_ie, c_lvl, d_lvl, irq;
  logic [7:0] irq_en = 8'h00, c_dv = 8'h00, d_dv = 8'h00, c_den = 8'hff, d_den = 8'hff;
  logic t1a_en = 1'b0, t1a = 1'b0, t1b_en = 1'b0, t1b = 1'b0, t0b_en = 1'b0, t0b = 1'b0;
  logic tx_en = 1'b0, tx_d = 1'b0, rx_en = 1'b0, rx_rdy = 1'b0, cts_en = 1'b0;
  logic rts_en = 1'b0, sync = 1'b0, sclk = 1'b0, cp_en = 1'b0, cn_en = 1'b0, slp = 1'b0;
  logic [12:8] pc_en = 5'h00, pcg;
  logic t0cnt, rxd, allow, sclk_o, cp, cn;
  int fails = 0;
  int total_checks = 0;

  always #50 sys_clk_i = ~sys_clk_i;

  pcdaf_top DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .portc_pad_i(c_lvl), .portc_pad_o(c_o), .portc_pad_oe_o(c_oe), .portc_pullup_o(c_pu),
    .portc_input_en_o(c_ie), .portd_pad_i(d_lvl), .portd_pad_o(d_o), .portd_pad_oe_o(d_oe),
    .portd_pullup_o(d_pu), .portd_input_en_o(d_ie),
    .timer1_compare_a_en_i(t1a_en), .timer1_compare_a_out_i(t1a),
    .timer1_compare_b_en_i(t1b_en), .timer1_compare_b_out_i(t1b),
    .timer0_compare_b_en_i(t0b_en), .timer0_compare_b_out_i(t0b),
    .timer0_count_input_o(t0cnt), .serial_tx_enable_i(tx_en), .serial_tx_data_i(tx_d),
    .serial_rx_enable_i(rx_en), .serial_rx_ready_i(rx_rdy), .serial_cts_en_i(cts_en),
    .serial_rts_en_i(rts_en), .serial_sync_mode_i(sync), .serial_sync_clock_out_i(sclk),
    .serial_rx_data_o(rxd), .serial_tx_allow_o(allow), .serial_sync_clock_o(sclk_o),
    .ext_irq_en_i(irq_en), .pin_change_en_i(pc_en), .comparator_pos_en_i(cp_en),
    .comparator_neg_en_i(cn_en), .sleep_i(slp), .ext_irq_o(irq), .pin_change_o(pcg),
    .comparator_pos_in_o(cp), .comparator_neg_in_o(cn));

  pcdaf_board brd_c (.sys_clk_i(sys_clk_i), .pad_o_i(c_o), .pad_oe_i(c_oe),
    .pullup_i(c_pu), .drv_en_i(c_den), .drv_val_i(c_dv), .level_o(c_lvl));
  pcdaf_board brd_d (.sys_clk_i(sys_clk_i), .pad_o_i(d_o), .pad_oe_i(d_oe),
    .pullup_i(d_pu), .drv_en_i(d_den), .drv_val_i(d_dv), .level_o(d_lvl));

  // ***************************************************
  // shared tasks
  // ***************************************************
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one avalon access: hold everything until waitrequest is sampled low
  task automatic bus(input logic r, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    logic lo;
    int n;
    lo = 1'b0;
    n = 0;
    @(posedge sys_clk_i);
    adr <= a;
    wdat <= {24'h0, d};
    be <= b;
    rd <= r;
    wr <= ~r;
    while (!lo) begin
      @(negedge sys_clk_i);
      lo = (wreq === 1'b0);
      @(posedge sys_clk_i);
      n++;
      if (n > 20) begin
        fails++;
        $display("MISMATCH t=%0t bus timeout", $time);
        summarize();
      end
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wrr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, 4'hf, q);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string m);
    logic [31:0] q;
    bus(1'b1, a, 8'h00, 4'hf, q);
    chk(q, e, m);
  endtask

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_regs();
    logic [31:0] q;
    chk({d_oe, d_o, d_pu, c_oe}, 32'h0, "pads idle after reset");
    chk({8'h00, c_ie & 8'hf7, d_ie, 7'h00, allow}, 32'h00f7ff01, "reset inputs");
    wrr(pcdaf_pkg::PORTC_DATA_OFS, 8'hff);
    rdc(pcdaf_pkg::PORTC_DATA_OFS, 32'h000000f7, "portc gap bit");
    bus(1'b0, pcdaf_pkg::PORTC_DIR_OFS, 8'hff, 4'he, q);
    rdc(pcdaf_pkg::PORTC_DIR_OFS, 32'h0, "lane 0 off");
    wrr(5'h1c, 8'h5a);
    rdc(5'h1c, 32'h0, "unmapped");
    d_dv <= 8'ha5;
    settle(8);
    wrr(pcdaf_pkg::PORTD_PIN_OFS, 8'h5a);
    rdc(pcdaf_pkg::PORTD_PIN_OFS, 32'h000000a5, "pin register");
    wrr(pcdaf_pkg::PORTD_DIR_OFS, 8'hff);
    wrr(pcdaf_pkg::PORTD_DATA_OFS, 8'h3c);
    settle(2);
    chk({d_oe, d_o, d_pu}, 24'hff3c00, "port drive");
    wrr(pcdaf_pkg::PORTD_DIR_OFS, 8'h00);
    settle(2);
    chk(d_pu, 8'h3c, "base pull-up");
    wrr(pcdaf_pkg::CTRL_OFS, 8'h01);
    settle(2);
    chk(d_pu, 8'h00, "pull-up disable");
    wrr(pcdaf_pkg::CTRL_OFS, 8'h00);
    wrr(pcdaf_pkg::PORTC_DATA_OFS, 8'h00);
    d_dv <= 8'h00;
    $display("test regs done");
  endtask

  task automatic t_serial();
    wrr(pcdaf_pkg::PORTD_DATA_OFS, 8'h0c);
    wrr(pcdaf_pkg::PORTD_DIR_OFS, 8'h04);
    tx_en <= 1'b1;
    tx_d <= 1'b1;
    rx_en <= 1'b1;
    settle(2);
    chk({d_oe[3], d_o[3], d_pu[3]}, 3'b110, "tx forced out");
    chk({d_oe[2], d_pu[2]}, 2'b01, "rx forced in");
    tx_d <= 1'b0;
    settle(2);
    chk(d_o[3], 1'b0, "tx data");
    wrr(pcdaf_pkg::CTRL_OFS, 8'h01);
    settle(2);
    chk(d_pu[2], 1'b0, "rx pull-up gated");
    wrr(pcdaf_pkg::CTRL_OFS, 8'h00);
    tx_en <= 1'b0;
    rx_en <= 1'b0;
    settle(2);
    chk({d_oe[3:2], d_pu[3]}, 3'b011, "tx rx released");
    $display("test serial done");
  endtask

  task automatic t_flow();
    wrr(pcdaf_pkg::PORTD_DATA_OFS, 8'h80);
    wrr(pcdaf_pkg::PORTD_DIR_OFS, 8'h80);
    cts_en <= 1'b1;
    rts_en <= 1'b1;
    rx_rdy <= 1'b1;
    d_dv <= 8'h80;
    settle(8);
    chk({d_oe[7], d_pu[7], d_oe[6], d_o[6]}, 4'b0110, "cts in, rts out");
    chk({allow, t0cnt}, 2'b01, "cts high holds tx");
    rx_rdy <= 1'b0;
    d_dv <= 8'h00;
    settle(8);
    chk({allow, t0cnt, d_o[6]}, 3'b101, "cts low, rts");
    cts_en <= 1'b0;
    rts_en <= 1'b0;
    $display("test flow done");
  endtask

  task automatic t_sync();
    wrr(pcdaf_pkg::PORTD_DATA_OFS, 8'h00);
    wrr(pcdaf_pkg::PORTD_DIR_OFS, 8'h20);
    sync <= 1'b1;
    sclk <= 1'b1;
    settle(2);
    chk({d_oe[5], d_o[5]}, 2'b11, "clock out");
    sclk <= 1'b0;
    settle(2);
    chk(d_o[5], 1'b0, "clock out low");
    sync <= 1'b0;
    wrr(pcdaf_pkg::PORTD_DATA_OFS, 8'h20);
    settle(2);
    chk(d_o[5], 1'b1, "plain port");
    wrr(pcdaf_pkg::PORTD_DIR_OFS, 8'h00);
    sync <= 1'b1;
    d_dv <= 8'h20;
    settle(8);
    chk(sclk_o, 1'b1, "clock in");
    sync <= 1'b0;
    settle(2);
    chk(sclk_o, 1'b0, "clock off");
    $display("test sync done");
  endtask

  task automatic t_timer();
    wrr(pcdaf_pkg::PORTC_DIR_OFS, 8'h60);
    t1a_en <= 1'b1;
    t1a <= 1'b1;
    t1b_en <= 1'b1;
    settle(2);
    chk({c_oe[6:5], c_o[6:5], c_pu[7:4]}, 8'b11100000, "timer1 a");
    t1a <= 1'b0;
    t1b <= 1'b1;
    settle(2);
    chk(c_o[6:5], 2'b01, "timer1 b");
    wrr(pcdaf_pkg::PORTD_DIR_OFS, 8'h01);
    t0b_en <= 1'b1;
    t0b <= 1'b1;
    settle(2);
    chk({d_oe[0], d_o[0]}, 2'b11, "timer0 b high");
    t0b <= 1'b0;
    settle(2);
    chk(d_o[0], 1'b0, "timer0 b low");
    t0b_en <= 1'b0;
    t0b <= 1'b1;
    settle(2);
    chk(d_o[0], 1'b0, "timer0 b off");
    t1a_en <= 1'b0;
    t1b_en <= 1'b0;
    wrr(pcdaf_pkg::PORTC_DIR_OFS, 8'h00);
    wrr(pcdaf_pkg::PORTD_DIR_OFS, 8'h00);
    $display("test timer done");
  endtask

  task automatic t_inputs();
    c_dv <= 8'h80;
    d_dv <= 8'hd6;
    settle(8);
    chk(irq, 8'hf6, "irq map");
    chk({t0cnt, cp, cn}, 3'b111, "count and comparator");
    c_dv <= 8'h54;
    d_dv <= 8'hf6;
    slp <= 1'b1;
    irq_en <= 8'hff;
    pc_en <= 5'h1f;
    settle(8);
    chk(pcg, 5'b11101, "pin change map");
    chk({c_ie & 8'hf7, d_ie}, 16'hf4ff, "inputs kept on");
    cp_en <= 1'b1;
    cn_en <= 1'b1;
    d_dv <= 8'hf4;
    settle(8);
    chk({d_ie, cp, cn}, {8'hf9, 2'b01}, "comparator path");
    irq_en <= 8'h00;
    pc_en <= 5'h00;
    cp_en <= 1'b0;
    cn_en <= 1'b0;
    settle(2);
    chk(d_ie, 8'h00, "inputs off asleep");
    slp <= 1'b0;
    $display("test inputs done");
  endtask

  initial begin
    repeat (6) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    settle(1);
    t_regs();
    t_serial();
    t_flow();
    t_sync();
    t_timer();
    t_inputs();
    summarize();
  end
endmodule

`default_nettype wire
